//--- qpc_pkg.sv
package qpc_pkg;

    // ****************************************
    // Frame layout, shifted in MSB first
    // ****************************************
    localparam int          FRAME_BITS = 17;
    localparam int          OP_MSB     = 16;
    localparam int          OP_LSB     = 13;
    localparam int          CH_MSB     = 12;
    localparam int          CH_LSB     = 11;
    localparam int          SLOT_MSB   = 10;
    localparam int          SLOT_LSB   = 9;
    localparam int          BUF_BIT    = 8;
    localparam logic [4:0]  CNT_FULL   = 5'h11;

    // ****************************************
    // Sizes and values after reset
    // ****************************************
    localparam int          TAP_W         = 8;
    localparam int          WORD_W        = 9;
    localparam int          NUM_CH        = 4;
    localparam int          NUM_SLOT      = 4;
    localparam logic [7:0]  TAP_MIN       = 8'h00;
    localparam logic [7:0]  TAP_MAX       = 8'hff;
    localparam logic [7:0]  TAP_RESET     = 8'h00;
    localparam logic [8:0]  NV_RESET_WORD = 9'h080;
    localparam logic [1:0]  DEFAULT_SLOT  = 2'h0;
    localparam logic [1:0]  LAST_CH       = 2'h3;

    // ****************************************
    // Command opcodes
    // ****************************************
    localparam logic [3:0]  OP_WR_TAP  = 4'h1;
    localparam logic [3:0]  OP_SAVE    = 4'h2;
    localparam logic [3:0]  OP_UP      = 4'h3;
    localparam logic [3:0]  OP_DOWN    = 4'h4;
    localparam logic [3:0]  OP_WR_NV   = 4'h5;
    localparam logic [3:0]  OP_RECALL  = 4'h6;
    localparam logic [3:0]  OP_RD_NV   = 4'h7;
    localparam logic [3:0]  OP_RD_TAP  = 4'h8;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_BOOT_LOAD,
        ST_IDLE,
        ST_FETCH
    } qpc_state_type;

endpackage

//--- qpc_setting_mem.sv
`timescale 1ns/1ps
module qpc_setting_mem #(
    parameter int         WIDTH      = 9,
    parameter int         DEPTH      = 16,
    parameter int         AW         = 4,
    parameter logic [8:0] RESET_WORD = 9'h080
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             rd_en_in,
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage array; reset stands in for factory-fresh contents
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= RESET_WORD[WIDTH-1:0];
            end
        end else if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Registered read, one cycle of latency
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else if (rd_en_in) begin
            rd_data_out <= mem[rd_addr_in];
        end
    end

endmodule

//--- qpc_serial_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// R01 - Sample serial_in on each rising serial clock while select is low.
// R02 - Host sends all command content only through serial_in.
// R03 - Select high: deselected, serial_out released, standby unless storing.
// R04 - Select low enables device into active power state.
// R05 - Host must make a select falling edge before any accepted command.
// R06 - Read data leaves on open-drain serial_out, changing on falling clock.
// R07 - First read bit appears at select falling edge, before any clock.
// R08 - serial_out doubles as cascade output for daisy chains.
// R09 - Open-drain active-low done acknowledges commands 2, 4, 5, 6, 7.
// R10 - Write guard low blocks all changes except recall into tap register.
// R11 - Each channel has 256 wiper positions from its tap setting.
// R12 - Four independent channels, each with its own tap setting.
// R13 - Four stored locations per channel, directly writable and readable.
// R14 - Tap setting loads from serial data or a stored location.
// R15 - Save copies channel tap setting into any chosen stored slot.
// R16 - At power-up each channel loads its default slot.
// R17 - Output buffer selection kept separately per channel.
// R18 - Buffer bit acts only via stored write then recall, off when 0.
// R19 - Up and down move one step and saturate at the ends.
// R20 - Each stored word is nine bits: tap plus buffer bit.
// R21 - Ignore clock while deselected; drop partial frames on early select rise.
// R22 - One fixed instruction table: 17-bit frame, opcode, channel, slot, data.
module qpc_serial_ctrl (
    input  wire logic        MCLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        SER_CLK_IN,
    input  wire logic        DEV_SELECT_N_IN,
    input  wire logic        SERIAL_IN_IN,
    input  wire logic        WRITE_GUARD_N_IN,
    output logic             SERIAL_OUT_OUT,
    output logic             SERIAL_OUT_OE_OUT,
    output logic             CMD_DONE_N_OUT,
    output logic             CMD_DONE_N_OE_OUT,
    output logic             ACTIVE_OUT,
    output logic [31:0]      TAP_SETTING_OUT,
    output logic [3:0]       BUFFER_EN_OUT
);
    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    // Bit 0 serial clock, 1 select, 2 serial_in, 3 write guard
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [1:0] pin_prev;
    // Two flops per pin, plus a third on clock and select for edge detection; the first stage is never read by logic
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pin_meta <= 4'ha;
            pin_sync <= 4'ha;
            pin_prev <= 2'h2;
        end else begin
            pin_meta <= {WRITE_GUARD_N_IN, SERIAL_IN_IN, DEV_SELECT_N_IN, SER_CLK_IN};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync[1:0];
        end
    end
    logic sel_n;
    logic sin;
    logic guard_ok;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;
    assign sel_n     = pin_sync[1];
    assign sin       = pin_sync[2];
    assign guard_ok  = pin_sync[3];
    assign sclk_rise = pin_sync[0] & ~pin_prev[0] & ~sel_n;
    assign sclk_fall = ~pin_sync[0] & pin_prev[0] & ~sel_n;
    assign sel_fall  = ~sel_n & pin_prev[1];
    assign sel_rise  = sel_n & ~pin_prev[1];
    // ****************************************
    // Shift register and frame tracking
    // ****************************************
    qpc_pkg::qpc_state_type state;
    logic [qpc_pkg::FRAME_BITS-1:0] shreg;
    logic [4:0]                     bit_cnt;
    logic                           frame_ok;
    logic [7:0]                     tap [qpc_pkg::NUM_CH];
    logic [3:0]                     buf_en;
    logic [1:0]                     boot_ch;
    logic [3:0]                     cur_op;
    logic [1:0]                     cur_ch;
    logic [8:0]                     mem_rd_data;
    logic [3:0] op;
    logic [1:0] ch;
    logic [1:0] slot;
    logic       exec;
    // R22 fixed layout
    assign op   = shreg[qpc_pkg::OP_MSB:qpc_pkg::OP_LSB];
    assign ch   = shreg[qpc_pkg::CH_MSB:qpc_pkg::CH_LSB];
    assign slot = shreg[qpc_pkg::SLOT_MSB:qpc_pkg::SLOT_LSB];
    // R21 partial frames dropped
    assign exec = (state == qpc_pkg::ST_IDLE) && sel_rise && frame_ok && (bit_cnt == qpc_pkg::CNT_FULL);
    // R01 shift on rising clock; R08 cascade: old content moves towards serial_out
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            shreg <= '0;
        end else if (sclk_rise) begin
            shreg <= {shreg[qpc_pkg::FRAME_BITS-2:0], sin};
        end else if (state == qpc_pkg::ST_FETCH && cur_op == qpc_pkg::OP_RD_NV) begin
            shreg <= {8'h00, mem_rd_data};
        end else if (exec && op == qpc_pkg::OP_RD_TAP) begin
            shreg <= {8'h00, buf_en[ch], tap[ch]};
        end
    end
    // Bit counter saturates so long daisy-chain frames keep the last 17 bits
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            bit_cnt <= '0;
        end else if (sel_fall) begin
            bit_cnt <= '0;
        end else if (sclk_rise && bit_cnt != qpc_pkg::CNT_FULL) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end
    // R05 frame counts only after its own select fall; each select rise clears it
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            frame_ok <= 1'b0;
        end else if (sel_fall) begin
            frame_ok <= 1'b1;
        end else if (sel_rise) begin
            frame_ok <= 1'b0;
        end
    end
    // ****************************************
    // Sequencer, stored settings and taps
    // ****************************************
    logic       mem_wr_en;
    logic [8:0] mem_wr_data;
    logic       mem_rd_en;
    logic [3:0] mem_rd_addr;
    // R10 guard blocks writes; R15 save takes current tap; R13 direct write
    always_comb begin
        mem_wr_en   = exec && guard_ok && (op == qpc_pkg::OP_SAVE || op == qpc_pkg::OP_WR_NV);
        mem_wr_data = (op == qpc_pkg::OP_SAVE) ? {buf_en[ch], tap[ch]} : shreg[8:0];
        mem_rd_en   = (state == qpc_pkg::ST_BOOT) || (exec && (op == qpc_pkg::OP_RECALL || op == qpc_pkg::OP_RD_NV));
        mem_rd_addr = (state == qpc_pkg::ST_BOOT) ? {boot_ch, qpc_pkg::DEFAULT_SLOT} : {ch, slot};
    end
    // R20 nine-bit words, four slots per channel
    qpc_setting_mem #(
        .WIDTH      (qpc_pkg::WORD_W),
        .DEPTH      (qpc_pkg::NUM_CH * qpc_pkg::NUM_SLOT),
        .AW         (4),
        .RESET_WORD (qpc_pkg::NV_RESET_WORD)
    ) u_mem (
        .clk_in      (MCLK_IN),
        .rst_n_in    (RSTN_IN),
        .wr_en_in    (mem_wr_en),
        .wr_addr_in  ({ch, slot}),
        .wr_data_in  (mem_wr_data),
        .rd_en_in    (mem_rd_en),
        .rd_addr_in  (mem_rd_addr),
        .rd_data_out (mem_rd_data)
    );
    // Boot walks all channels, then serves commands
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state <= qpc_pkg::ST_BOOT;
        end else begin
            unique case (state)
                qpc_pkg::ST_BOOT:      state <= qpc_pkg::ST_BOOT_LOAD;
                qpc_pkg::ST_BOOT_LOAD: state <= (boot_ch == qpc_pkg::LAST_CH) ? qpc_pkg::ST_IDLE : qpc_pkg::ST_BOOT;
                qpc_pkg::ST_IDLE: begin
                    if (exec && (op == qpc_pkg::OP_RECALL || op == qpc_pkg::OP_RD_NV)) begin
                        state <= qpc_pkg::ST_FETCH;
                    end
                end
                qpc_pkg::ST_FETCH:     state <= qpc_pkg::ST_IDLE;
            endcase
        end
    end
    // Boot channel index and latched command for the fetch cycle
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            boot_ch <= '0;
            cur_op  <= '0;
            cur_ch  <= '0;
        end else begin
            if (state == qpc_pkg::ST_BOOT_LOAD) begin
                boot_ch <= boot_ch + 2'h1;
            end
            if (exec) begin
                cur_op <= op;
                cur_ch <= ch;
            end
        end
    end
    // R12 one register per channel; R16 boot load; R14 serial or recall source
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < qpc_pkg::NUM_CH; i++) begin
                tap[i] <= qpc_pkg::TAP_RESET;
            end
            buf_en <= '0;
        end else if (state == qpc_pkg::ST_BOOT_LOAD) begin
            tap[boot_ch]    <= mem_rd_data[7:0];
            buf_en[boot_ch] <= mem_rd_data[qpc_pkg::BUF_BIT];
        end else if (state == qpc_pkg::ST_FETCH && cur_op == qpc_pkg::OP_RECALL) begin
            // R18 buffer bit only arrives through recall or the boot load; R10 recall allowed under guard
            tap[cur_ch]    <= mem_rd_data[7:0];
            buf_en[cur_ch] <= mem_rd_data[qpc_pkg::BUF_BIT];
        end else if (exec && guard_ok) begin
            // R19 saturating steps; direct write leaves buffer bit alone
            if (op == qpc_pkg::OP_WR_TAP) begin
                tap[ch] <= shreg[7:0];
            end else if (op == qpc_pkg::OP_UP && tap[ch] != qpc_pkg::TAP_MAX) begin
                tap[ch] <= tap[ch] + 8'h01;
            end else if (op == qpc_pkg::OP_DOWN && tap[ch] != qpc_pkg::TAP_MIN) begin
                tap[ch] <= tap[ch] - 8'h01;
            end
        end
    end
    // R11 eight bits give 256 positions; R17 buffer bit per channel
    for (genvar g = 0; g < qpc_pkg::NUM_CH; g++) begin : g_tap
        assign TAP_SETTING_OUT[g*qpc_pkg::TAP_W +: qpc_pkg::TAP_W] = tap[g];
    end
    assign BUFFER_EN_OUT = buf_en;
    // ****************************************
    // Serial output, power state, done flag
    // ****************************************
    logic active;
    logic out_bit;
    logic done;
    logic done_set;
    // R04 active while selected; R03 standby once released
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            active <= 1'b0;
        end else begin
            active <= ~sel_n;
        end
    end
    // R07 first bit at select fall; R06 later bits on falling clock
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            out_bit <= 1'b1;
        end else if (sel_fall || sclk_fall) begin
            out_bit <= shreg[qpc_pkg::FRAME_BITS-1];
        end
    end
    // R09 acknowledged commands only
    assign done_set = (exec && guard_ok &&
                       (op == qpc_pkg::OP_SAVE || op == qpc_pkg::OP_DOWN || op == qpc_pkg::OP_WR_NV)) ||
                      (state == qpc_pkg::ST_FETCH && (cur_op == qpc_pkg::OP_RECALL || cur_op == qpc_pkg::OP_RD_NV));
    // Set wins over the clear by the next frame's select fall
    always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            done <= 1'b0;
        end else if (done_set) begin
            done <= 1'b1;
        end else if (sel_fall) begin
            done <= 1'b0;
        end
    end
    // Open drain: pull low only; serial_out released when deselected, done held until the next select fall
    assign SERIAL_OUT_OUT    = 1'b0;
    assign SERIAL_OUT_OE_OUT = active & ~out_bit;
    assign CMD_DONE_N_OUT    = 1'b0;
    assign CMD_DONE_N_OE_OUT = done;
    assign ACTIVE_OUT        = active;
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    sequence s_recall_exec;
        exec && op == qpc_pkg::OP_RECALL;
    endsequence
    sequence s_fetch;
        state == qpc_pkg::ST_FETCH;
    endsequence
    sdo_release_a: assert property (sel_n |=> !SERIAL_OUT_OE_OUT) // R03
        else $error("serial_out driven while deselected");
    active_entry_a: assert property (sel_fall |=> ACTIVE_OUT ##1 ACTIVE_OUT || sel_n) // R04
        else $error("not active after select fall");
    shift_in_a: assert property (sclk_rise |=> shreg[0] == $past(sin)) // R01
        else $error("serial_in bit not shifted");
    first_bit_a: assert property (sel_fall |=> out_bit == $past(shreg[qpc_pkg::FRAME_BITS-1])) // R07
        else $error("first bit not presented at select fall");
    fall_shift_a: assert property (sclk_fall |=> out_bit == $past(shreg[qpc_pkg::FRAME_BITS-1])) // R06
        else $error("output bit not updated on falling clock");
    recall_done_a: assert property (s_recall_exec ##1 s_fetch |=> CMD_DONE_N_OE_OUT) // R09
        else $error("recall not acknowledged");
    guard_block_a: assert property (exec && !guard_ok && op != qpc_pkg::OP_RECALL |=> $stable(TAP_SETTING_OUT)) // R10
        else $error("tap changed under write guard");
    up_sat_a: assert property (exec && guard_ok && op == qpc_pkg::OP_UP && tap[ch] == qpc_pkg::TAP_MAX
                               |=> $stable(TAP_SETTING_OUT)) // R19
        else $error("up step wrapped");
    partial_drop_a: assert property (state == qpc_pkg::ST_IDLE && sel_rise && bit_cnt != qpc_pkg::CNT_FULL
                                     |=> state == qpc_pkg::ST_IDLE && $stable(TAP_SETTING_OUT)) // R21
        else $error("partial frame executed");
    boot_load_a: assert property (state == qpc_pkg::ST_BOOT_LOAD && boot_ch == 2'h0
                                  |=> TAP_SETTING_OUT[7:0] == $past(mem_rd_data[7:0])) // R16
        else $error("default slot not loaded at boot");
endmodule

//--- qpc_host_model.sv
`timescale 1ns/1ps
module qpc_host_model (
    input  wire logic mclk_in,
    input  wire logic reply_in,
    output logic      ser_clk_out,
    output logic      select_n_out,
    output logic      data_out
);
    // Half of the 80 ns link period, in system cycles
    localparam int HALF = 4;

    // Idle link: clock parked low, select high
    initial begin
        ser_clk_out  = 1'b0;
        select_n_out = 1'b1;
        data_out     = 1'b0;
    end

    task automatic half_wait();
        repeat (HALF) @(negedge mclk_in);
    endtask

    // content only on data line, each frame opens with select fall
    task automatic frame(input logic [16:0] word, input int nbits, output logic [16:0] rx);
        int i;
        rx = 17'h00000;
        @(negedge mclk_in);
        select_n_out = 1'b0;
        for (i = 0; i < nbits; i++) begin
            data_out = word[16-i];
            half_wait();
            rx = {rx[15:0], reply_in}; // Settled reply, taken just before the rise
            ser_clk_out = 1'b1;
            half_wait();
            ser_clk_out = 1'b0;
        end
        half_wait();
        select_n_out = 1'b1;
        data_out = ~data_out; // Released line never shows a stale copy
        repeat (2*HALF) @(negedge mclk_in);
    endtask

    // Clock and data wiggled while deselected, a real host may do so
    task automatic idle_clocks(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            data_out = ~data_out;
            ser_clk_out = ~ser_clk_out;
            half_wait();
        end
        ser_clk_out = 1'b0;
    endtask
endmodule

//--- quad_pot_serial_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp, what) \
    begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: %s", $time, what); end end
module quad_pot_serial_control_tb_top;
    // ****************************************
    // Clock, reset and wiring
    // ****************************************
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        guard_n = 1'b1;
    logic        ser_clk, sel_n, serial_in;
    logic        ser_o, ser_oe, done_o, done_oe, active;
    logic [31:0] taps;
    logic [3:0]  buf_en;
    logic        ser_wire, done_wire;
    logic [16:0] rx;
    int          failures = 0;
    int          check_count = 0;

    // Both open-drain lines pulled up when released
    assign ser_wire  = ser_oe ? ser_o : 1'b1;
    assign done_wire = done_oe ? done_o : 1'b1;

    // 100 MHz system clock
    always #5 mclk = ~mclk;

    qpc_serial_ctrl dut_u (
        .MCLK_IN          (mclk),
        .RSTN_IN          (rstn),
        .SER_CLK_IN       (ser_clk),
        .DEV_SELECT_N_IN  (sel_n),
        .SERIAL_IN_IN     (serial_in),
        .WRITE_GUARD_N_IN (guard_n),
        .SERIAL_OUT_OUT   (ser_o),
        .SERIAL_OUT_OE_OUT(ser_oe),
        .CMD_DONE_N_OUT   (done_o),
        .CMD_DONE_N_OE_OUT(done_oe),
        .ACTIVE_OUT       (active),
        .TAP_SETTING_OUT  (taps),
        .BUFFER_EN_OUT    (buf_en)
    );

    qpc_host_model host_u (
        .mclk_in     (mclk),
        .reply_in    (ser_wire),
        .ser_clk_out (ser_clk),
        .select_n_out(sel_n),
        .data_out    (serial_in)
    );

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic send(input logic [3:0] op, input logic [1:0] ch, input logic [1:0] slot,
                        input logic [8:0] data);
        host_u.frame({op, ch, slot, data}, 17, rx);
    endtask

    task automatic chk_tap(input int ch, input logic [7:0] exp);
        `CHK(taps[8*ch +: 8], exp, "tap value")
    endtask

    task automatic chk_done(input logic exp);
        `CHK(done_wire, exp, "done line")
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_boot();
        int c;
        for (c = 0; c < 4; c++) begin
            chk_tap(c, 8'h80);
        end
        `CHK(buf_en, 4'h0, "buffer after boot")
        `CHK({ser_wire, active}, 2'b10, "deselected outputs")
    endtask

    task automatic t_write_active();
        fork
            send(qpc_pkg::OP_WR_TAP, 2'h2, 2'h0, 9'h05a);
            begin
                repeat (8) @(negedge mclk);
                `CHK(active, 1'b1, "active while selected")
            end
        join
        chk_tap(2, 8'h5a);
        chk_tap(1, 8'h80);
        chk_done(1'b1);
    endtask

    task automatic t_updown();
        send(qpc_pkg::OP_WR_TAP, 2'h1, 2'h0, 9'h0ff);
        send(qpc_pkg::OP_UP, 2'h1, 2'h0, 9'h000);
        chk_tap(1, qpc_pkg::TAP_MAX);
        chk_done(1'b1);
        send(qpc_pkg::OP_DOWN, 2'h1, 2'h0, 9'h000);
        chk_tap(1, 8'hfe);
        chk_done(1'b0);
        send(qpc_pkg::OP_WR_TAP, 2'h1, 2'h0, 9'h000);
        send(qpc_pkg::OP_DOWN, 2'h1, 2'h0, 9'h000);
        chk_tap(1, qpc_pkg::TAP_MIN);
    endtask

    task automatic t_stored();
        send(qpc_pkg::OP_WR_NV, 2'h0, 2'h3, 9'h1a5);
        chk_done(1'b0);
        chk_tap(0, 8'h80);
        send(qpc_pkg::OP_RD_NV, 2'h0, 2'h3, 9'h000);
        chk_done(1'b0);
        host_u.frame(17'h01234, 17, rx);
        `CHK(rx, 17'h001a5, "stored word read")
        host_u.frame(17'h00000, 17, rx);
        `CHK(rx, 17'h01234, "cascade pass")
        send(qpc_pkg::OP_RECALL, 2'h0, 2'h3, 9'h000);
        chk_tap(0, 8'ha5);
        `CHK(buf_en, 4'h1, "buffer from recall")
        chk_done(1'b0);
        send(qpc_pkg::OP_WR_TAP, 2'h0, 2'h0, 9'h033);
        send(qpc_pkg::OP_WR_TAP, 2'h3, 2'h0, 9'h180);
        `CHK(buf_en, 4'h1, "direct write keeps buffer")
        chk_tap(0, 8'h33);
        send(qpc_pkg::OP_RD_TAP, 2'h0, 2'h0, 9'h000);
        chk_done(1'b1);
        host_u.frame(17'h00000, 17, rx);
        `CHK(rx, 17'h00133, "tap read back")
    endtask

    task automatic t_save();
        send(qpc_pkg::OP_SAVE, 2'h2, 2'h1, 9'h000);
        chk_done(1'b0);
        send(qpc_pkg::OP_RD_NV, 2'h2, 2'h1, 9'h000);
        host_u.frame(17'h00000, 17, rx);
        `CHK(rx, 17'h0005a, "saved word")
    endtask

    task automatic t_guard();
        @(negedge mclk);
        guard_n = 1'b0;
        repeat (6) @(negedge mclk);
        send(qpc_pkg::OP_WR_TAP, 2'h3, 2'h0, 9'h011);
        chk_tap(3, 8'h80);
        chk_done(1'b1);
        send(qpc_pkg::OP_WR_NV, 2'h0, 2'h3, 9'h000);
        chk_done(1'b1);
        send(qpc_pkg::OP_RECALL, 2'h0, 2'h3, 9'h000);
        chk_tap(0, 8'ha5);
        chk_done(1'b0);
        guard_n = 1'b1;
        repeat (6) @(negedge mclk);
    endtask

    task automatic t_partial();
        host_u.frame({qpc_pkg::OP_WR_TAP, 2'h3, 2'h0, 9'h044}, 10, rx);
        chk_tap(3, 8'h80);
        host_u.idle_clocks(20);
        chk_tap(3, 8'h80);
        send(qpc_pkg::OP_WR_TAP, 2'h3, 2'h0, 9'h044);
        chk_tap(3, 8'h44);
    endtask

    // Watchdog, far above the length of the sequence
    initial begin
        #600000;
        failures++;
        $display("mismatch at %0t: run did not finish", $time);
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        repeat (12) @(negedge mclk);
        t_boot();
        t_write_active();
        t_updown();
        t_stored();
        t_save();
        t_guard();
        t_partial();
        give_verdict();
    end
endmodule
